// File: rtl/sqpr_responder.v
// sqpr_responder.v: serial slave that answers single-packet extended status queries
// assumes: host is serial master, mode 0 (sample on rising, shift on falling), clock <= 5 MHz,
// host checks spi_busy low before each byte; status inputs are quasi-static on ref_clk.
`timescale 1ns/10ps
`include "sqpr_defines.vh"

module sqpr_responder
(
  input wire ref_clk,
  input wire rst_n,
  input wire spi_clk,
  input wire spi_cs_n,
  input wire spi_mosi,
  output reg spi_miso,
  output wire spi_busy,
  input wire flash_prog_mode,
  input wire reset_driver_link_fail,
  input wire mirror_link_fail,
  input wire light_driver_link_fail,
  input wire [2:0] seq_mode,
  input wire [15:0] patterns_per_frame,
  input wire pixel_depth_eight,
  output reg query_done,
  output reg query_error
);

  localparam ST_RX = 2'h0;
  localparam ST_PROC = 2'h1;
  localparam ST_TX = 2'h2;

  function [7:0] pick_byte;
    input [`SQPR_REP_BYTES-1:0] vec;
    input [3:0] idx;
    begin
      pick_byte = vec[idx*8 +: 8];
    end
  endfunction

  // one-bit fault or mode flag as a status byte
  function [7:0] flag_byte;
    input flag;
    begin
      flag_byte = flag ? `SQPR_FAIL : `SQPR_OK;
    end
  endfunction

  // three-stage pin synchroniser, order {clk, cs_n, mosi}
  // resets to the idle levels so no false edge follows reset
  reg [2:0] pin_s1;
  reg [2:0] pin_s2;
  reg [2:0] pin_s3;
  reg [2:0] pin_lvl;
  wire [2:0] next_pin_lvl;
  // a level moves only once stages two and three agree
  assign next_pin_lvl = (pin_s2 & pin_s3) | (pin_lvl & (pin_s2 ^ pin_s3));

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1 <= `SQPR_PIN_RESET;
      pin_s2 <= `SQPR_PIN_RESET;
      pin_s3 <= `SQPR_PIN_RESET;
      pin_lvl <= `SQPR_PIN_RESET;
    end
    else
    begin
      pin_s1 <= {spi_clk, spi_cs_n, spi_mosi};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_lvl <= next_pin_lvl;
    end
  end

  wire sel = ~next_pin_lvl[1];
  wire clk_rise = next_pin_lvl[2] & ~pin_lvl[2] & sel;
  wire clk_fall = ~next_pin_lvl[2] & pin_lvl[2] & sel;
  // synchronised clock still high in either stage
  wire clk_high = next_pin_lvl[2] | pin_lvl[2];
  wire rx_bit = next_pin_lvl[0];

  reg [1:0] state;
  reg [2:0] bit_cnt;
  reg [3:0] byte_idx;
  reg [6:0] rx_shift;
  reg [`SQPR_REQ_BYTES-1:0] req;
  reg [`SQPR_REP_BYTES-1:0] rep;
  reg [3:0] rep_last;
  // last request bit's falling edge reaches the reply state while select may stay low
  reg skip_fall;

  // busy only while the reply is latched; the host must not clock then
  assign spi_busy = (state == ST_PROC);

  // request decode
  wire [7:0] r_first_command_byte = req[7:0];
  wire [7:0] r_packet_class_byte = req[15:8];
  wire [7:0] r_third_command_byte = req[23:16];
  wire [7:0] r_transfer_position_byte = req[31:24];
  wire [7:0] r_len_lo = req[39:32];
  wire [7:0] r_len_hi = req[47:40];
  wire [15:0] r_id = req[63:48];
  wire [7:0] r_sum = req[71:64];
  wire [7:0] calc_sum = r_len_lo + r_len_hi + req[55:48] + req[63:56];

  reg [7:0] res0;
  reg [7:0] len;
  reg [7:0] d2;
  reg [7:0] d3;
  reg [7:0] rep_sum;
  reg [`SQPR_REP_BYTES-1:0] bld;

  always @*
  begin
    res0 = `SQPR_OK;
    d2 = `SQPR_OK;
    d3 = `SQPR_OK;
    len = `SQPR_LEN_ONE;
    if (r_first_command_byte != `SQPR_READ_CODE || r_packet_class_byte != `SQPR_EXT_CLASS)
      res0[`SQPR_ERR_HEADER] = 1'b1;
    if (r_third_command_byte != `SQPR_ZERO_BYTE || r_transfer_position_byte != `SQPR_ZERO_BYTE)
      res0[`SQPR_ERR_HEADER] = 1'b1;
    if (r_len_lo != `SQPR_REQ_LEN || r_len_hi != `SQPR_ZERO_BYTE)
      res0[`SQPR_ERR_LENGTH] = 1'b1;
    if (calc_sum != r_sum)
      res0[`SQPR_ERR_CHECKSUM] = 1'b1;
    case (r_id)
      `SQPR_ID_PROG:
        d2 = flag_byte(flash_prog_mode);
      `SQPR_ID_RESET_DRV:
        d2 = flag_byte(reset_driver_link_fail);
      `SQPR_ID_MIRROR:
        d2 = flag_byte(mirror_link_fail);
      `SQPR_ID_LIGHT:
        d2 = flag_byte(light_driver_link_fail);
      `SQPR_ID_SEQ_MODE:
        d2 = {5'h00, seq_mode};
      `SQPR_ID_PATTERNS:
      begin
        d2 = patterns_per_frame[7:0];
        d3 = patterns_per_frame[15:8];
        len = `SQPR_LEN_TWO;
      end
      `SQPR_ID_DEPTH:
        d2 = pixel_depth_eight ? `SQPR_DEPTH_EIGHT : `SQPR_DEPTH_ONE;
      default:
        res0[`SQPR_ERR_ID] = 1'b1;
    endcase
    // any fault drops the status bytes
    if (res0 != `SQPR_OK)
    begin
      len = `SQPR_LEN_SHORT;
      d2 = `SQPR_OK;
      d3 = `SQPR_OK;
    end
    // unused status bytes are zero, so they add nothing to the sum
    rep_sum = len + res0 + d2 + d3;
    bld = {`SQPR_REP_BYTES{1'b0}};
    bld[7:0] = `SQPR_READ_REPLY_CODE;
    bld[15:8] = `SQPR_EXT_CLASS;
    bld[23:16] = `SQPR_ZERO_BYTE;
    bld[31:24] = `SQPR_ZERO_BYTE;
    bld[39:32] = len;
    bld[47:40] = `SQPR_ZERO_BYTE;
    bld[55:48] = res0;
    bld[63:56] = `SQPR_OK;
    bld[71:64] = d2;
    bld[79:72] = d3;
    case (len)
      `SQPR_LEN_SHORT:
        bld[71:64] = rep_sum;
      `SQPR_LEN_ONE:
        bld[79:72] = rep_sum;
      default:
        bld[87:80] = rep_sum;
    endcase
  end

  wire [3:0] next_byte_idx = byte_idx + 4'h1;
  wire [2:0] next_bit_cnt = bit_cnt + 3'h1;
  wire [7:0] cur_byte = pick_byte(rep, byte_idx);
  wire [7:0] nxt_byte = pick_byte(rep, next_byte_idx);

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_RX;
      bit_cnt <= 3'h0;
      byte_idx <= 4'h0;
      rx_shift <= 7'h00;
      req <= {`SQPR_REQ_BYTES{1'b0}};
      rep <= {`SQPR_REP_BYTES{1'b0}};
      rep_last <= 4'h0;
      skip_fall <= 1'b0;
      spi_miso <= 1'b0;
      query_done <= 1'b0;
      query_error <= 1'b0;
    end
    else
    begin
      query_done <= 1'b0;
      case (state)
        ST_RX:
        begin
          // byte position survives a deselect so the host may pause between bytes
          if (!sel)
            bit_cnt <= 3'h0;
          else if (clk_rise)
          begin
            rx_shift <= {rx_shift[5:0], rx_bit};
            bit_cnt <= next_bit_cnt;
            if (bit_cnt == 3'h7)
            begin
              req[byte_idx*8 +: 8] <= {rx_shift, rx_bit};
              if (byte_idx == `SQPR_REQ_LAST)
              begin
                byte_idx <= 4'h0;
                state <= ST_PROC;
              end
              else
                byte_idx <= next_byte_idx;
            end
          end
        end
        ST_PROC:
        begin
          // one cycle of busy while the reply is latched
          rep <= bld;
          rep_last <= len[3:0] + 4'h6;
          spi_miso <= bld[7];
          bit_cnt <= 3'h0;
          byte_idx <= 4'h0;
          skip_fall <= clk_high;
          query_done <= 1'b1;
          query_error <= (res0 != `SQPR_OK);
          state <= ST_TX;
        end
        ST_TX:
        begin
          // the host owns the frame; the reply is held until fully clocked out
          // a bit moves three to four core cycles after a falling edge: fits a 100 ns low phase
          if (!sel)
          begin
            bit_cnt <= 3'h0;
            skip_fall <= 1'b0;
            spi_miso <= cur_byte[7];
          end
          else if (clk_fall && skip_fall)
          begin
            // that edge ends the request, it must not shift the reply
            skip_fall <= 1'b0;
          end
          else if (clk_fall)
          begin
            bit_cnt <= next_bit_cnt;
            if (bit_cnt == 3'h7)
            begin
              if (byte_idx == rep_last)
              begin
                byte_idx <= 4'h0;
                spi_miso <= 1'b0;
                state <= ST_RX;
              end
              else
              begin
                byte_idx <= next_byte_idx;
                spi_miso <= nxt_byte[7];
              end
            end
            else
              spi_miso <= cur_byte[3'h7 - next_bit_cnt];
          end
        end
        default:
          state <= ST_RX;
      endcase
    end
  end

endmodule // sqpr_responder

// File: include/sqpr_defines.vh
// sqpr_defines.vh: packet codes, field values and error bits of the status query responder
// assumes inclusion by rtl/sqpr_responder.v and by the testbench
`ifndef SQPR_DEFINES_VH
`define SQPR_DEFINES_VH

// command bytes
`define SQPR_READ_CODE 8'h04
`define SQPR_READ_REPLY_CODE 8'h05
`define SQPR_EXT_CLASS 8'haa
`define SQPR_ZERO_BYTE 8'h00
`define SQPR_REQ_LEN 8'h02

// request frame: 4 command, 2 length, 2 id, 1 checksum
`define SQPR_REQ_BYTES 72
`define SQPR_REQ_LAST 4'h8

// reply frame storage: up to 11 bytes
`define SQPR_REP_BYTES 88

// reply payload lengths
`define SQPR_LEN_SHORT 8'h02
`define SQPR_LEN_ONE 8'h03
`define SQPR_LEN_TWO 8'h04

// query identifiers
`define SQPR_ID_PROG 16'h001b
`define SQPR_ID_RESET_DRV 16'h001c
`define SQPR_ID_MIRROR 16'h001d
`define SQPR_ID_LIGHT 16'h001e
`define SQPR_ID_SEQ_MODE 16'h001f
`define SQPR_ID_PATTERNS 16'h0020
`define SQPR_ID_DEPTH 16'h0021

// status values
`define SQPR_OK 8'h00
`define SQPR_FAIL 8'h01
`define SQPR_DEPTH_ONE 8'h01
`define SQPR_DEPTH_EIGHT 8'h08

// error bits of the first result byte
`define SQPR_ERR_HEADER 0
`define SQPR_ERR_LENGTH 1
`define SQPR_ERR_CHECKSUM 2
`define SQPR_ERR_ID 3

// synchroniser reset level, order {clk, cs_n, mosi}
`define SQPR_PIN_RESET 3'h2

`endif

// File: verif/sqpr_monitor.sv
// sqpr_monitor.sv: port-level assertions on the status query responder
// assumes bind onto sqpr_responder; every check runs in the ref_clk domain
`timescale 1ns/10ps
module sqpr_monitor
(
  input wire ref_clk,
  input wire rst_n,
  input wire spi_clk,
  input wire spi_cs_n,
  input wire spi_miso,
  input wire spi_busy,
  input wire query_done,
  input wire query_error
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_BUSY_PULSE: assert property (spi_busy |=> (!spi_busy)[*8])
    else $error("busy not a single cycle");
  AST_DONE_FOLLOWS: assert property (spi_busy |-> ##[0:1] query_done)
    else $error("no done after busy");
  AST_DONE_CAUSE: assert property (query_done |-> spi_busy || $past(spi_busy))
    else $error("done without busy");
  AST_DONE_SINGLE: assert property (query_done |=> !query_done)
    else $error("done longer than one cycle");
  AST_ERR_HELD: assert property ($changed(query_error) |-> query_done || $past(spi_busy))
    else $error("error flag moved outside a query");
  AST_BUSY_SELECTED: assert property (spi_busy |-> !spi_cs_n)
    else $error("busy without a selected request");
  AST_REPLY_MSB: assert property (spi_busy |=> ##1 (!spi_miso)[*8])
    else $error("reply first bit not zero");
  // data may only move after a falling edge has passed the synchroniser
  AST_MISO_STEADY: assert property (spi_clk && $past(spi_clk) && $past(spi_clk, 2) && $past(spi_clk, 3)
    |-> $stable(spi_miso))
    else $error("reply data moved while clock high");
endmodule // sqpr_monitor

bind sqpr_responder sqpr_monitor mon (.ref_clk(ref_clk), .rst_n(rst_n), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
  .spi_miso(spi_miso), .spi_busy(spi_busy), .query_done(query_done), .query_error(query_error));

// File: verif/sqpr_host.sv
// sqpr_host.sv: serial master model that sends one request and reads the whole reply
// assumes mode 0 slave; clock stands low outside bytes, 200 ns bit time
`timescale 1ns/10ps
module sqpr_host
(
  output reg spi_clk,
  output reg spi_cs_n,
  output reg spi_mosi,
  input wire spi_miso
);
  logic [7:0] rep_q[$];
  logic keep_sel = 1'b0;
  initial
  begin
    spi_clk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  task xfer(input logic [7:0] tx, output logic [7:0] rx);
    integer i;
    for (i = 7; i >= 0; i--)
    begin
      #50 spi_mosi = tx[i];
      #50 spi_clk = 1'b1;
      rx[i] = spi_miso;
      #100 spi_clk = 1'b0;
    end
  endtask
  // released data line shows the inverse of its last level
  task frame(input logic [71:0] req);
    logic [7:0] rx;
    integer n;
    spi_cs_n = 1'b0;
    for (n = 8; n >= 0; n--) xfer(req[n*8 +: 8], rx);
    // select may stay low between request and reply
    #200 spi_cs_n = !keep_sel;
    spi_mosi = ~spi_mosi;
    rep_q = {};
    #1000 spi_cs_n = 1'b0;
    for (n = 0; n < 6 || n < rep_q[4] + 7; n++)
    begin
      xfer(8'h5a ^ n[7:0], rx);
      rep_q.push_back(rx);
    end
    #200 spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
  endtask
endmodule // sqpr_host

// File: verif/testbench.sv
// testbench.sv: query every identifier and each error bit, compare with a byte model
// assumes sqpr_host as serial master; status inputs change 2 ns after ref_clk rises
`timescale 1ns/10ps
`include "sqpr_defines.vh"
module testbench;
  reg ref_clk = 1'b0;
  reg rst_n = 1'b0;
  reg flash_prog_mode = 1'b0, reset_driver_link_fail = 1'b0, mirror_link_fail = 1'b0;
  reg light_driver_link_fail = 1'b0, pixel_depth_eight = 1'b0;
  reg [2:0] seq_mode = 3'h0;
  reg [15:0] patterns_per_frame = 16'h0000;
  wire spi_clk, spi_cs_n, spi_mosi, spi_miso, spi_busy, query_done, query_error;
  integer n_errors = 0;
  integer samples_checked = 0;
  integer seed = 7;
  integer n_done = 0;
  integer k;
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (query_done === 1'b1) n_done++;
  sqpr_responder uut (.ref_clk(ref_clk), .rst_n(rst_n), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_busy(spi_busy), .flash_prog_mode(flash_prog_mode),
    .reset_driver_link_fail(reset_driver_link_fail), .mirror_link_fail(mirror_link_fail),
    .light_driver_link_fail(light_driver_link_fail), .seq_mode(seq_mode),
    .patterns_per_frame(patterns_per_frame), .pixel_depth_eight(pixel_depth_eight),
    .query_done(query_done), .query_error(query_error));
  sqpr_host host (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso));
  task check(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (exp !== got)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task complete_run;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task query(input logic [7:0] c1, c4, len, input logic [15:0] id, input logic [7:0] bad);
    logic [7:0] r0, cks;
    logic [7:0] pl[$];
    integer d0;
    @(posedge ref_clk);
    #2 {flash_prog_mode, reset_driver_link_fail, mirror_link_fail} = 3'($random(seed));
    {light_driver_link_fail, pixel_depth_eight} = 2'($random(seed));
    seq_mode = 3'({$random(seed)} % 5);
    patterns_per_frame = 16'($random(seed));
    d0 = n_done;
    cks = len + id[7:0] + id[15:8] + bad;
    host.frame({c1, `SQPR_EXT_CLASS, 8'h00, c4, len, 8'h00, id[7:0], id[15:8], cks});
    r0 = {4'h0, id < 16'h001b || id > 16'h0021, bad != 8'h00, len != 8'h02, c1 != 8'h04 || c4 != 8'h00};
    pl = {r0, 8'h00};
    if (r0 == 8'h00)
      case (id[7:0])
        8'h1b: pl.push_back({7'h0, flash_prog_mode});
        8'h1c: pl.push_back({7'h0, reset_driver_link_fail});
        8'h1d: pl.push_back({7'h0, mirror_link_fail});
        8'h1e: pl.push_back({7'h0, light_driver_link_fail});
        8'h1f: pl.push_back({5'h0, seq_mode});
        8'h20: pl = {pl, patterns_per_frame[7:0], patterns_per_frame[15:8]};
        default: pl.push_back(pixel_depth_eight ? 8'h08 : 8'h01);
      endcase
    cks = 8'(pl.size());
    foreach (pl[j]) cks += pl[j];
    pl = {8'h05, 8'haa, 8'h00, 8'h00, 8'(pl.size()), 8'h00, pl, cks};
    check("reply size", pl.size(), host.rep_q.size());
    foreach (pl[j]) check("reply byte", pl[j], host.rep_q[j]);
    check("done pulses", d0 + 1, n_done);
    check("error flag", r0 != 8'h00, query_error);
  endtask
  initial
  begin
    repeat (10) @(posedge ref_clk);
    #2 rst_n = 1'b1;
    repeat (8) @(posedge ref_clk);
    for (k = 16'h1b; k <= 16'h21; k++)
      repeat (2) query(8'h04, 8'h00, 8'h02, k[15:0], 8'h00);
    host.keep_sel = 1'b1;
    query(8'h04, 8'h00, 8'h02, 16'h001b, 8'h00);
    query(8'h04, 8'h00, 8'h02, 16'h0020, 8'h00);
    host.keep_sel = 1'b0;
    query(8'h04, 8'h00, 8'h02, 16'h0022, 8'h00);
    query(8'h04, 8'h00, 8'h02, 16'h011c, 8'h00);
    query(8'h04, 8'h00, 8'h02, 16'h001c, 8'($random(seed)) | 8'h01);
    query(8'h05, 8'h00, 8'h02, 16'h001d, 8'h00);
    query(8'h04, 8'h01, 8'h02, 16'h001e, 8'h00);
    query(8'h04, 8'h00, 8'h03, 16'h001f, 8'h00);
    complete_run;
  end
  // about 30 us per query; limit leaves ample margin
  initial
  begin
    #2000000;
    n_errors++;
    complete_run;
  end
endmodule // testbench
